// ### rtl/scl_channel.sv
// serial channel with link-type reporting and test-loop paths
//
// Behaviour
// [RULE_01] link type set: every modem-status change also pushed into the receive fifo
// [RULE_02] link type clear: modem status shown in status only, never pushed
// [RULE_03] software sets link type for any channel wired to a modem
// [RULE_04] test-loop select is read/write; code 00 is normal operation
// [RULE_05] echo: received characters resent at receive rate, transmit allow ignored
// [RULE_06] echo: received characters still stored in the receive fifo
// [RULE_07] echo: host characters for transmission are discarded
// [RULE_08] software keeps receive allow set during echo
// [RULE_09] local loop: host characters routed into the receive path
// [RULE_10] local loop: serial input ignored, serial output held at mark
// [RULE_11] local loop: transmit rate clocks both sending and receiving
// [RULE_12] local loop: transmit allow gates sending, receive allow ignored
// [RULE_13] remote loop: incoming line sent straight back at received rate
// [RULE_14] remote loop: looped characters never written to the receive fifo
// [RULE_15] remote loop: transmit allow disregarded
// [RULE_16] software keeps receive allow set during remote loop
// [RULE_17] modem entry: bits 14:12 are 111, low byte holds modem status
// [RULE_18] test-loop changes take effect only at a character boundary
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module scl_channel (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // serial line
    input  wire logic        rxd_i,
    output logic             txd_o,
    // modem leads
    input  wire logic        dsr_i,
    input  wire logic        ri_i,
    input  wire logic        dcd_i,
    input  wire logic        cts_i,
    // interrupt
    output logic             irq_o
);
    import scl_pkg::*;

    // byte-lane merge for register writes
    function automatic logic [31:0] scl_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // registers
    logic [31:0]       ctrl_reg;
    logic [31:0]       rate_reg;
    logic [INT_W-1:0]  istat_reg;
    logic [INT_W-1:0]  imask_reg;
    scl_mode_e         mode_reg;
    logic [7:0]        hold_reg;
    logic              hold_full_reg;
    logic [7:0]        echo_char_reg;
    logic              echo_pend_reg;
    logic [7:0]        modem_prev_reg;
    logic              modem_pend_reg;
    scl_tx_e           tx_state_reg;
    logic [9:0]        tx_shift_reg;
    logic [3:0]        tx_tick_cnt_reg;
    logic [3:0]        tx_bit_reg;
    scl_rx_e           rx_state_reg;
    logic [7:0]        rx_shift_reg;
    logic [3:0]        rx_tick_cnt_reg;
    logic [3:0]        rx_bit_reg;
    logic [14:0]       fifo_mem [0:(1<<FIFO_AW)-1];
    logic [FIFO_AW-1:0] wr_ptr_reg;
    logic [FIFO_AW-1:0] rd_ptr_reg;
    logic [FIFO_AW:0]  count_reg;

    // bus access decode
    logic wb_acc, wb_wr, wb_rd;
    logic hit_ctrl, hit_rate, hit_stat, hit_tx, hit_rxw, hit_ist, hit_imk;
    assign wb_acc   = cyc_i & stb_i & ~ack_o;
    assign wb_wr    = wb_acc & we_i;
    assign wb_rd    = wb_acc & ~we_i;
    assign hit_ctrl = (adr_i == ADR_CTRL);
    assign hit_rate = (adr_i == ADR_RATE);
    assign hit_stat = (adr_i == ADR_STAT);
    assign hit_tx   = (adr_i == ADR_TXDATA);
    assign hit_rxw  = (adr_i == ADR_RXWORD);
    assign hit_ist  = (adr_i == ADR_ISTAT);
    assign hit_imk  = (adr_i == ADR_IMASK);

    // control fields
    logic      rx_allow, tx_allow, link_type;
    scl_mode_e mode_req;
    assign rx_allow  = ctrl_reg[CTRL_RX_ALLOW];
    assign tx_allow  = ctrl_reg[CTRL_TX_ALLOW];
    assign link_type = ctrl_reg[CTRL_LINK_TYPE];
    assign mode_req  = scl_mode_e'(ctrl_reg[CTRL_LOOP_LSB +: 2]);

    // mode decode on the active path
    logic m_echo, m_local, m_remote;
    assign m_echo   = (mode_reg == MODE_ECHO);
    assign m_local  = (mode_reg == MODE_LOCAL);
    assign m_remote = (mode_reg == MODE_REMOTE);

    // rate dividers
    logic tx_rate_tick, rx_rate_tick;
    scl_rate_gen u_tx_rate (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .div_i  (rate_reg[DIV_W-1:0]),
        .tick_o (tx_rate_tick)
    );
    scl_rate_gen u_rx_rate (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .div_i  (rate_reg[RATE_RX_LSB +: DIV_W]),
        .tick_o (rx_rate_tick)
    );

    // path selection per active mode
    logic tx_tick, rx_tick, tx_line, rx_line, rx_en;
    assign tx_tick = m_echo ? rx_rate_tick : tx_rate_tick;     // RULE_05
    assign rx_tick = m_local ? tx_rate_tick : rx_rate_tick;    // RULE_11
    assign tx_line = (tx_state_reg == TX_SHIFT) ? tx_shift_reg[0] : 1'b1;
    assign rx_line = m_local ? tx_line : rxd_i;                // RULE_09 RULE_10
    assign rx_en   = m_local | rx_allow;                       // RULE_12

    // transmitter load source
    logic       load_req, tx_start, tx_end;
    logic [7:0] load_char;
    assign load_req  = m_echo   ? echo_pend_reg                // RULE_05
                     : m_remote ? 1'b0                         // RULE_15
                     : hold_full_reg & tx_allow;               // RULE_12
    assign load_char = m_echo ? echo_char_reg : hold_reg;
    assign tx_start  = (tx_state_reg == TX_IDLE) & load_req;
    assign tx_end    = (tx_state_reg == TX_SHIFT) & tx_tick
                     & (tx_tick_cnt_reg == TICK_LAST) & (tx_bit_reg == TX_LAST_BIT);

    // transmitter: start, eight data bits, stop, at sixteen ticks a bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state_reg    <= TX_IDLE;
            tx_shift_reg    <= 10'h3ff;
            tx_tick_cnt_reg <= 4'h0;
            tx_bit_reg      <= 4'h0;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (tx_start) begin
                        tx_state_reg    <= TX_SHIFT;
                        tx_shift_reg    <= {1'b1, load_char, 1'b0};
                        tx_tick_cnt_reg <= 4'h0;
                        tx_bit_reg      <= 4'h0;
                    end
                end
                TX_SHIFT: begin
                    if (tx_tick) begin
                        tx_tick_cnt_reg <= tx_tick_cnt_reg + 4'h1;
                        if (tx_tick_cnt_reg == TICK_LAST) begin
                            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                            tx_bit_reg   <= tx_bit_reg + 4'h1;
                        end
                        if (tx_end) begin
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // receiver done strobe: stop bit seen high at mid-bit
    logic rx_done, rx_push;
    assign rx_done = (rx_state_reg == RX_DATA) & rx_tick & (rx_tick_cnt_reg == TICK_LAST)
                   & (rx_bit_reg == RX_STOP_BIT) & rx_line;
    assign rx_push = rx_done & ~m_remote;                      // RULE_06 RULE_14

    // receiver: find start edge, check at mid-bit, then sample every sixteen ticks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_state_reg    <= RX_IDLE;
            rx_shift_reg    <= 8'h00;
            rx_tick_cnt_reg <= 4'h0;
            rx_bit_reg      <= 4'h0;
        end else begin
            case (rx_state_reg)
                RX_IDLE: begin
                    rx_tick_cnt_reg <= 4'h0;
                    rx_bit_reg      <= 4'h0;
                    if (rx_en & ~rx_line) begin
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_tick_cnt_reg <= rx_tick_cnt_reg + 4'h1;
                        if (rx_tick_cnt_reg == TICK_MID) begin
                            rx_tick_cnt_reg <= 4'h0;
                            rx_state_reg    <= rx_line ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_tick_cnt_reg <= rx_tick_cnt_reg + 4'h1;
                        if (rx_tick_cnt_reg == TICK_LAST) begin
                            rx_bit_reg <= rx_bit_reg + 4'h1;
                            if (rx_bit_reg == RX_STOP_BIT) begin
                                rx_state_reg <= RX_IDLE;
                            end else begin
                                rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                            end
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // modem status byte as it appears in the status high byte
    logic [7:0] modem_byte;
    logic       modem_change, modem_push;
    assign modem_byte   = {dsr_i, 1'b0, ri_i, dcd_i, cts_i, 3'b000};
    assign modem_change = (modem_byte != modem_prev_reg);
    assign modem_push   = modem_pend_reg & link_type & ~rx_push;   // RULE_01 RULE_02

    // fifo push selection, characters first
    logic        push, pop, full, empty;
    logic [14:0] push_word;
    assign push      = rx_push | modem_push;
    assign push_word = rx_push ? {TAG_CHAR, 4'h0, rx_shift_reg}
                     : {TAG_MODEM, 4'h0, modem_prev_reg};          // RULE_17
    assign full      = (count_reg == (FIFO_AW+1)'(1 << FIFO_AW));
    assign empty     = (count_reg == '0);
    assign pop       = wb_rd & hit_rxw & ~empty;

    // receive fifo storage
    always_ff @(posedge clk_i) begin
        if (push & ~full) begin
            fifo_mem[wr_ptr_reg] <= push_word;
        end
    end

    // fifo pointers and fill count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + FIFO_AW'(push & ~full);
            rd_ptr_reg <= rd_ptr_reg + FIFO_AW'(pop);
            count_reg  <= count_reg + (FIFO_AW+1)'(push & ~full) - (FIFO_AW+1)'(pop);
        end
    end

    // modem tracking; a fresh change wins over the push that clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            modem_prev_reg <= 8'h00;
            modem_pend_reg <= 1'b0;
        end else begin
            modem_prev_reg <= modem_byte;
            modem_pend_reg <= link_type & (modem_change | (modem_pend_reg & ~modem_push));
        end
    end

    // host holding register and echo pending character
    logic hold_wr, char_gap;
    assign hold_wr  = wb_wr & hit_tx & sel_i[0] & ~m_echo;     // RULE_07
    assign char_gap = (tx_state_reg == TX_IDLE) & (rx_state_reg == RX_IDLE) & ~echo_pend_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_reg      <= 8'h00;
            hold_full_reg <= 1'b0;
            echo_char_reg <= 8'h00;
            echo_pend_reg <= 1'b0;
            mode_reg      <= MODE_NORMAL;
        end else begin
            if (hold_wr) begin
                hold_reg <= dat_i[7:0];
            end
            hold_full_reg <= hold_wr | (hold_full_reg & ~(tx_start & ~m_echo) & ~m_echo);
            if (rx_done & m_echo) begin
                echo_char_reg <= rx_shift_reg;
            end
            echo_pend_reg <= (rx_done & m_echo) | (echo_pend_reg & ~tx_start);
            if (char_gap) begin
                mode_reg <= mode_req;                          // RULE_18
            end
        end
    end

    // events: set wins over read-clear
    logic [INT_W-1:0] events;
    logic             ist_clr;
    assign events[INT_RX]      = rx_push;
    assign events[INT_TX_DONE] = tx_end;
    assign events[INT_MODEM]   = modem_push;
    assign events[INT_OVERRUN] = push & full;
    assign ist_clr             = wb_rd & hit_ist;
    wire logic [31:0] imask_wide = scl_merge({28'h000_0000, imask_reg}, dat_i, sel_i);

    // software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg  <= CTRL_RESET;
            rate_reg  <= RATE_RESET;
            imask_reg <= INT_RESET;
            istat_reg <= INT_RESET;
        end else begin
            if (wb_wr & hit_ctrl) begin
                ctrl_reg <= scl_merge(ctrl_reg, dat_i, sel_i) & CTRL_MASK;   // RULE_04
            end
            if (wb_wr & hit_rate) begin
                rate_reg <= scl_merge(rate_reg, dat_i, sel_i);
            end
            if (wb_wr & hit_imk) begin
                imask_reg <= imask_wide[INT_W-1:0];
            end
            istat_reg <= (ist_clr ? INT_RESET : istat_reg) | events;
        end
    end

    // read data selection
    logic [31:0] stat_word, rxw_word, rd_data;
    assign stat_word = {16'h0000, modem_byte, 3'b000, (tx_state_reg == TX_SHIFT),
                        ~empty, hold_full_reg, mode_reg};
    assign rxw_word  = {16'h0000, ~empty, fifo_mem[rd_ptr_reg]};
    assign rd_data   = hit_ctrl ? ctrl_reg
                     : hit_rate ? rate_reg
                     : hit_stat ? stat_word
                     : hit_rxw  ? (empty ? 32'h0000_0000 : rxw_word)
                     : hit_ist  ? {28'h000_0000, istat_reg}
                     : hit_imk  ? {28'h000_0000, imask_reg}
                     : 32'h0000_0000;

    // single-wait-state acknowledge, registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wb_acc;
            if (wb_rd) begin
                dat_o <= rd_data;
            end
        end
    end

    // serial output: mark in local loop, raw line in remote loop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txd_o <= 1'b1;
        end else begin
            txd_o <= m_local ? 1'b1 : m_remote ? rxd_i : tx_line;  // RULE_10 RULE_13
        end
    end

    assign irq_o = |(istat_reg & imask_reg);

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_LOOP_RW: assert property (wb_wr & hit_ctrl & sel_i[0] |=> ctrl_reg[7:6] == $past(dat_i[7:6])) // RULE_04
        else $error("test-loop field did not take the written value");
    AST_MODEM_PUSH: assert property (link_type & modem_change ##1 link_type |-> ##[0:1] modem_push) // RULE_01
        else $error("modem change not pushed into receive fifo");
    AST_NO_MODEM_PUSH: assert property (!link_type |-> !modem_push) // RULE_02
        else $error("modem entry pushed while link type clear");
    AST_MODEM_TAG: assert property (modem_push |-> push_word[14:12] == 3'b111 && push_word[7:0] == modem_prev_reg) // RULE_17
        else $error("modem entry malformed");
    AST_ECHO_RETX: assert property (rx_done & m_echo & (tx_state_reg == TX_IDLE) |-> ##2 tx_state_reg == TX_SHIFT) // RULE_05
        else $error("echo character not resent");
    AST_ECHO_DROP: assert property (m_echo ##1 m_echo |-> !hold_full_reg) // RULE_07
        else $error("host character kept in echo mode");
    AST_LOCAL_MARK: assert property (m_local ##1 m_local |-> txd_o) // RULE_10
        else $error("serial output not at mark in local loop");
    AST_LOCAL_GATE: assert property (m_local & !tx_allow & (tx_state_reg == TX_IDLE) & !$changed(mode_reg) |=> tx_state_reg == TX_IDLE) // RULE_12
        else $error("transmission without transmit allow in local loop");
    AST_REMOTE_LOOP: assert property (m_remote ##1 m_remote |-> txd_o == $past(rxd_i)) // RULE_13
        else $error("remote loop output differs from input");
    AST_REMOTE_NOFIFO: assert property (m_remote |-> !rx_push) // RULE_14
        else $error("looped character written to receive fifo");
    AST_MODE_BOUNDARY: assert property ($changed(mode_reg) |-> $past(char_gap)) // RULE_18
        else $error("mode changed inside a character");
endmodule // scl_channel
`default_nettype wire

// ### rtl/scl_pkg.sv
// constants and types for the serial channel link and test-loop block
package scl_pkg;
    // wishbone register byte offsets
    localparam logic [4:0] ADR_CTRL   = 5'h00;
    localparam logic [4:0] ADR_RATE   = 5'h04;
    localparam logic [4:0] ADR_STAT   = 5'h08;
    localparam logic [4:0] ADR_TXDATA = 5'h0c;
    localparam logic [4:0] ADR_RXWORD = 5'h10;
    localparam logic [4:0] ADR_ISTAT  = 5'h14;
    localparam logic [4:0] ADR_IMASK  = 5'h18;
    // control register fields and reset
    localparam int          CTRL_RX_ALLOW  = 0;
    localparam int          CTRL_TX_ALLOW  = 1;
    localparam int          CTRL_LOOP_LSB  = 6;
    localparam int          CTRL_LINK_TYPE = 8;
    localparam logic [31:0] CTRL_MASK      = 32'h0000_01c3;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    // rate register: tx divisor low half, rx divisor high half
    localparam int          DIV_W       = 16;
    localparam int          RATE_RX_LSB = 16;
    localparam logic [31:0] RATE_RESET  = 32'h0010_0010;
    localparam logic [15:0] DIV_ONE     = 16'h0001;
    // oversampling: mid-bit tick, last tick, receiver stop-bit and transmitter last-bit indices
    localparam logic [3:0]  TICK_MID  = 4'h7;
    localparam logic [3:0]  TICK_LAST = 4'hf;
    localparam logic [3:0]  RX_STOP_BIT = 4'h8;
    localparam logic [3:0]  TX_LAST_BIT = 4'h9;
    // receive word layout
    localparam logic [2:0]  TAG_MODEM = 3'h7;
    localparam logic [2:0]  TAG_CHAR  = 3'h0;
    localparam int          RXW_VALID = 15;
    localparam int          FIFO_AW   = 2;
    // interrupt bits
    localparam int          INT_W       = 4;
    localparam int          INT_RX      = 0;
    localparam int          INT_TX_DONE = 1;
    localparam int          INT_MODEM   = 2;
    localparam int          INT_OVERRUN = 3;
    localparam logic [3:0]  INT_RESET   = 4'h0;
    // test-loop select codes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_ECHO   = 2'h1,
        MODE_LOCAL  = 2'h2,
        MODE_REMOTE = 2'h3
    } scl_mode_e;
    // transmitter and receiver states
    typedef enum logic [1:0] {
        TX_IDLE  = 2'h1,
        TX_SHIFT = 2'h2
    } scl_tx_e;
    typedef enum logic [2:0] {
        RX_IDLE  = 3'h1,
        RX_START = 3'h2,
        RX_DATA  = 3'h4
    } scl_rx_e;
endpackage : scl_pkg

// ### rtl/scl_rate_gen.sv
// divider giving a one-cycle oversampling tick
`timescale 1ns/1ps
`default_nettype none
module scl_rate_gen (
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // divisor in, tick out
    input  wire logic [scl_pkg::DIV_W-1:0] div_i,
    output logic                           tick_o
);
    import scl_pkg::*;

    logic [DIV_W-1:0] cnt_reg;

    // count down, pulse and reload at zero; a zero divisor ticks every cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            tick_o  <= 1'b0;
        end else begin
            tick_o  <= (cnt_reg == '0);
            cnt_reg <= (cnt_reg != '0) ? cnt_reg - DIV_ONE
                     : (div_i == '0)   ? '0 : div_i - DIV_ONE;
        end
    end
endmodule // scl_rate_gen
`default_nettype wire

// ### tb/scl_term.sv
// terminal and modem model on the far side of the serial channel
`timescale 1ns/1ps
`default_nettype none
module scl_term #(
    parameter int BIT = 16
) (
    // clock
    input  wire logic  clk_i,
    // serial line seen from the terminal
    input  wire logic  txd_i,
    output logic       rxd_o,
    // modem leads: dsr, ri, dcd, cts
    output logic [3:0] leads_o,
    // last character heard and how many
    output logic [7:0] got_o,
    output int         n_got_o
);
    // line rests at mark, leads off
    initial begin
        rxd_o = 1'b1;
        leads_o = 4'h0;
        got_o = 8'h00;
        n_got_o = 0;
    end
    // 8n1 frame, lsb first, line left at mark afterwards
    task automatic send(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o <= f[i];
            repeat (BIT) @(posedge clk_i);
        end
    endtask
    // change the modem leads just after an edge
    task automatic set_leads(input logic [3:0] v);
        @(posedge clk_i);
        leads_o <= v;
    endtask
    // hear frames from the channel, sampling mid-bit
    always begin
        @(negedge txd_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_i);
            got_o[i] = txd_i;
        end
        repeat (BIT) @(posedge clk_i);
        n_got_o++;
    end
endmodule // scl_term
`default_nettype wire

// ### tb/test_scl_channel.sv
// self-checking bench for link type and test-loop paths
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_scl_channel;
    import scl_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [4:0]  adr_i = 5'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [3:0]  lanes = 4'hf;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o, q;
    logic        ack_o, rxd_i, txd_o, irq_o;
    logic [3:0]  leads;
    logic [7:0]  got;
    int          n_got, n_mismatch = 0, comparisons = 0;
    // 250 MHz clock
    always #2 clk_i = ~clk_i;
    scl_channel u_scl_channel (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .rxd_i(rxd_i), .txd_o(txd_o), .dsr_i(leads[3]), .ri_i(leads[2]),
        .dcd_i(leads[1]), .cts_i(leads[0]), .irq_o(irq_o));
    scl_term u_scl_term (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .leads_o(leads),
        .got_o(got), .n_got_o(n_got));
    // one classic wishbone cycle; read data lands in q
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= lanes;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        if (n >= 40) n_mismatch++;
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // wait, bounded, until the terminal has heard k characters
    task automatic wait_chars(input int k);
        for (int n = 0; n < 3000 && n_got < k; n++) @(posedge clk_i);
        `CHK("chars heard", k, n_got)
    endtask
    task automatic t_reset();
        wb(1'b0, ADR_CTRL, 32'h0); `CHK("ctrl reset", CTRL_RESET, q)
        wb(1'b0, ADR_RATE, 32'h0); `CHK("rate reset", RATE_RESET, q)
        wb(1'b0, 5'h1c, 32'h0); `CHK("unmapped", 32'h0000_0000, q)
        wb(1'b1, ADR_CTRL, 32'hffff_ffff);
        wb(1'b0, ADR_CTRL, 32'h0); `CHK("ctrl rw", CTRL_MASK, q)
        lanes = 4'h1;
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        lanes = 4'hf;
        wb(1'b0, ADR_CTRL, 32'h0); `CHK("ctrl lane 0", 32'h0000_0100, q)
        wb(1'b1, ADR_RATE, 32'h0001_0001);
    endtask
    task automatic t_normal();
        wb(1'b1, ADR_CTRL, 32'h0000_0003);
        wb(1'b1, ADR_TXDATA, 32'h0000_00a5);
        wait_chars(1); `CHK("normal tx", 8'ha5, got)
        u_scl_term.send(8'h3c);
        repeat (4) @(posedge clk_i);
        wb(1'b0, ADR_RXWORD, 32'h0); `CHK("normal rx", 32'h0000_803c, q)
    endtask
    task automatic t_echo();
        wb(1'b1, ADR_CTRL, 32'h0000_0041);
        wb(1'b1, ADR_TXDATA, 32'h0000_0011);
        u_scl_term.send(8'h5a);
        wait_chars(2); `CHK("echo tx", 8'h5a, got)
        repeat (300) @(posedge clk_i);
        `CHK("host char dropped", 2, n_got)
        wb(1'b0, ADR_RXWORD, 32'h0); `CHK("echo rx", 32'h0000_805a, q)
    endtask
    task automatic t_remote();
        wb(1'b1, ADR_CTRL, 32'h0000_00c1);
        u_scl_term.send(8'h69);
        wait_chars(3); `CHK("remote loop", 8'h69, got)
        wb(1'b0, ADR_RXWORD, 32'h0); `CHK("remote no fifo", 32'h0000_0000, q)
    endtask
    task automatic t_local();
        wb(1'b1, ADR_RATE, 32'h0002_0001);
        wb(1'b1, ADR_CTRL, 32'h0000_0003);
        wb(1'b1, ADR_TXDATA, 32'h0000_0077);
        wb(1'b1, ADR_CTRL, 32'h0000_0083);
        wb(1'b0, ADR_STAT, 32'h0); `CHK("mode held", 2'h0, q[1:0])
        wait_chars(4); `CHK("last normal char", 8'h77, got)
        repeat (16) @(posedge clk_i);
        wb(1'b1, ADR_CTRL, 32'h0000_0081);
        wb(1'b0, ADR_STAT, 32'h0); `CHK("mode local", 2'h2, q[1:0])
        wb(1'b1, ADR_TXDATA, 32'h0000_004b);
        u_scl_term.send(8'h99);
        wb(1'b0, ADR_RXWORD, 32'h0); `CHK("gated, rx ignored", 32'h0000_0000, q)
        wb(1'b1, ADR_CTRL, 32'h0000_0082);
        repeat (250) @(posedge clk_i);
        wb(1'b0, ADR_RXWORD, 32'h0); `CHK("local loop", 32'h0000_804b, q)
        `CHK("line at mark", 4, n_got)
    endtask
    task automatic t_modem();
        wb(1'b1, ADR_CTRL, 32'h0000_0100);
        wb(1'b0, ADR_ISTAT, 32'h0);
        wb(1'b1, ADR_IMASK, 32'h0000_0004);
        u_scl_term.set_leads(4'ha);
        repeat (6) @(posedge clk_i);
        `CHK("irq raised", 1'b1, irq_o)
        wb(1'b0, ADR_ISTAT, 32'h0); `CHK("modem event", 32'h4, q & 32'h4)
        `CHK("irq cleared", 1'b0, irq_o)
        wb(1'b0, ADR_RXWORD, 32'h0); `CHK("modem entry", 32'h0000_f090, q)
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        u_scl_term.set_leads(4'h7);
        repeat (6) @(posedge clk_i);
        wb(1'b0, ADR_STAT, 32'h0); `CHK("status leads", 8'h38, q[15:8])
        wb(1'b0, ADR_RXWORD, 32'h0); `CHK("no entry", 32'h0000_0000, q)
        `CHK("irq quiet", 1'b0, irq_o)
    endtask
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // reset, then every scenario in turn
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_normal();
        t_echo();
        t_remote();
        t_local();
        t_modem();
        end_sim();
    end
    // watchdog well beyond the expected run
    initial begin
        repeat (30000) @(posedge clk_i);
        n_mismatch++;
        end_sim();
    end
endmodule // test_scl_channel
`default_nettype wire
